// [inband_loop_code_consts.vh]
// constants for the in-band loop code pattern block
// assumes a 50 MHz system clock and a word-wide classic Wishbone slave
`ifndef INBAND_LOOP_CODE_CONSTS_VH
`define INBAND_LOOP_CODE_CONSTS_VH

// register indexes, byte address is four times the index
`define IDX_INBAND_CODE_CONTROL 6'h0A
`define IDX_TX_PATTERN_LOW 6'h0B
`define IDX_TX_PATTERN_HIGH 6'h0C
`define IDX_RX_LOOPUP_PATTERN_LOW 6'h0D
`define IDX_RX_LOOPUP_PATTERN_HIGH 6'h0E
`define IDX_RX_LOOPDOWN_PATTERN_LOW 6'h0F
`define IDX_RX_LOOPDOWN_PATTERN_HIGH 6'h10
`define IDX_LOOPCODE_CONTROL 6'h13
`define IDX_LOOPCODE_STATUS 6'h14
`define IDX_IRQ_STATUS 6'h15
`define IDX_IRQ_MASK 6'h16

// field positions
`define TX_LEN_MSB 7
`define TX_LEN_LSB 6
`define UP_LEN_MSB 5
`define UP_LEN_LSB 3
`define DOWN_LEN_MSB 2
`define DOWN_LEN_LSB 0
`define TX_ENABLE_BIT 3
`define STAT_UP_BIT 7
`define STAT_DOWN_BIT 6
`define IRQ_UP_BIT 1
`define IRQ_DOWN_BIT 0

// reset values
`define RST_BYTE 8'h00

// detector timing
`define CLK_FREQ_MHZ 50
`define INTEG_TIME_MS 48
`define INTEG_CYCLES (`INTEG_TIME_MS * 1000 * `CLK_FREQ_MHZ)
`define ERR_RATIO 100
`define SLIP_LIMIT 5'd16
`define MIN_BITS 22'd16

`endif

// [loop_code_detector.v]
// one repeating-pattern detector for the receive line
// assumes bit_strobe_i marks one valid received bit, synchronous to clock_i
`timescale 1ns/100ps

`include "inband_loop_code_consts.vh"

module loop_code_detector #(
  parameter PERIOD_CYCLES = `INTEG_CYCLES
) (
  input wire clock_i,
  input wire rst_i,
  input wire bit_strobe_i,
  input wire bit_i,
  input wire [15:0] pattern_i,
  input wire [4:0] length_i,
  output wire detected_o
);

  // ****************************************
  // phase tracking
  // ****************************************
  reg [3:0] phase_q;
  reg [15:0] pat_q;
  reg [4:0] leak_q;
  reg [21:0] timer_q;
  reg [21:0] bits_q;
  reg [21:0] errs_q;
  reg det_q;
  wire expected;
  wire mismatch;
  wire slip;
  wire last_phase;

  // first phase takes the live pattern so a rewrite lands on a repetition start
  assign expected = (phase_q == 4'h0) ? pattern_i[15] : pat_q[4'hF - phase_q];
  assign mismatch = bit_i ^ expected;
  // a wrong phase gives frequent errors; hold the phase one bit to hunt
  assign slip = mismatch && (leak_q >= `SLIP_LIMIT - 5'd4);
  assign last_phase = ({1'b0, phase_q} >= length_i - 5'd1);

  always @(posedge clock_i) begin
    if (rst_i) begin
      phase_q <= 4'h0;
      pat_q <= 16'h0000;
      leak_q <= 5'h00;
    end else if (bit_strobe_i) begin
      if (phase_q == 4'h0)
        pat_q <= pattern_i;
      if (slip) begin
        leak_q <= 5'h00;
      end else if (mismatch) begin
        leak_q <= leak_q + 5'd4;
      end else if (leak_q != 5'h00) begin
        leak_q <= leak_q - 5'd1;
      end
      if (slip)
        phase_q <= phase_q;
      else if (last_phase)
        phase_q <= 4'h0;
      else
        phase_q <= phase_q + 4'h1;
    end
  end

  // ****************************************
  // integration window
  // ****************************************
  wire period_end;
  wire [31:0] err_scaled;
  assign period_end = ({10'h000, timer_q} == PERIOD_CYCLES - 1);
  // kept at the full width of the product so no bit is dropped
  assign err_scaled = {10'h000, errs_q} * `ERR_RATIO;

  always @(posedge clock_i) begin
    if (rst_i) begin
      timer_q <= 22'h000000;
      bits_q <= 22'h000000;
      errs_q <= 22'h000000;
      det_q <= 1'b0;
    end else if (period_end) begin
      timer_q <= 22'h000000;
      bits_q <= 22'h000000;
      errs_q <= 22'h000000;
      // one error in a hundred bits is still a detection
      det_q <= (bits_q >= `MIN_BITS) && (err_scaled <= {10'h000, bits_q});
    end else begin
      timer_q <= timer_q + 22'h000001;
      if (bit_strobe_i) begin
        bits_q <= bits_q + 22'h000001;
        if (mismatch)
          errs_q <= errs_q + 22'h000001;
      end
    end
  end

  assign detected_o = det_q;

endmodule // loop_code_detector

// [inband_loop_code_pattern_regs.v]
// in-band loop code generator, two detectors and their registers
// assumes line bits arrive and leave with one-cycle strobes on clock_i
// and that software uses classic Wishbone with 32-bit aligned words
`timescale 1ns/100ps

`include "inband_loop_code_consts.vh"

module inband_loop_code_pattern_regs #(
  parameter INTEG_CYCLES = `INTEG_CYCLES
) (
  input wire clock_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire tx_bit_strobe_i,
  input wire tx_line_data_i,
  output wire tx_data_o,
  input wire rx_bit_strobe_i,
  input wire rx_data_i,
  output wire loopup_detected_flag_o,
  output wire loopdown_detected_flag_o,
  output wire irq_o
);

  // ****************************************
  // length decoding
  // ****************************************
  function [4:0] rx_length;
    input [2:0] code;
    begin
      if (code == 3'h7)
        rx_length = 5'd16;
      else
        rx_length = {2'b00, code} + 5'd1;
    end
  endfunction

  function [4:0] tx_length;
    input [1:0] code;
    begin
      case (code)
        2'h0: tx_length = 5'd5;
        2'h1: tx_length = 5'd6;
        2'h2: tx_length = 5'd7;
        default: tx_length = 5'd16;
      endcase
    end
  endfunction

  // ****************************************
  // register file
  // ****************************************
  reg [7:0] code_control_q;
  reg [7:0] tx_low_q;
  reg [7:0] tx_high_q;
  reg [7:0] up_low_q;
  reg [7:0] up_high_q;
  reg [7:0] down_low_q;
  reg [7:0] down_high_q;
  reg tx_loopcode_enable_q;
  reg [1:0] irq_status_q;
  reg [1:0] irq_status_d;
  reg [1:0] irq_mask_q;
  reg irq_q;
  reg ack_q;
  reg [31:0] dat_q;
  reg [7:0] rd_byte;
  wire [5:0] index;
  wire request;
  wire wr_stb;
  wire up_live;
  wire down_live;
  reg up_prev_q;
  reg down_prev_q;

  assign index = wb_adr_i[7:2];
  // ack one cycle after the request, then low for a cycle
  assign request = wb_cyc_i && wb_stb_i && !ack_q;
  // only the low byte lane carries data
  assign wr_stb = request && wb_we_i && wb_sel_i[0];

  always @(posedge clock_i) begin
    if (rst_i) begin
      code_control_q <= `RST_BYTE;
      tx_low_q <= `RST_BYTE;
      tx_high_q <= `RST_BYTE;
      up_low_q <= `RST_BYTE;
      up_high_q <= `RST_BYTE;
      down_low_q <= `RST_BYTE;
      down_high_q <= `RST_BYTE;
      tx_loopcode_enable_q <= 1'b0;
      irq_mask_q <= 2'b00;
    end else if (wr_stb) begin
      case (index)
        `IDX_INBAND_CODE_CONTROL: code_control_q <= wb_dat_i[7:0];
        `IDX_TX_PATTERN_LOW: tx_low_q <= wb_dat_i[7:0];
        `IDX_TX_PATTERN_HIGH: tx_high_q <= wb_dat_i[7:0];
        `IDX_RX_LOOPUP_PATTERN_LOW: up_low_q <= wb_dat_i[7:0];
        `IDX_RX_LOOPUP_PATTERN_HIGH: up_high_q <= wb_dat_i[7:0];
        `IDX_RX_LOOPDOWN_PATTERN_LOW: down_low_q <= wb_dat_i[7:0];
        `IDX_RX_LOOPDOWN_PATTERN_HIGH: down_high_q <= wb_dat_i[7:0];
        `IDX_LOOPCODE_CONTROL: tx_loopcode_enable_q <= wb_dat_i[`TX_ENABLE_BIT];
        `IDX_IRQ_MASK: irq_mask_q <= {wb_dat_i[`IRQ_UP_BIT], wb_dat_i[`IRQ_DOWN_BIT]};
        default: begin
        end
      endcase
    end
  end

  // read mux: unmapped words read as zero and are still acknowledged
  always @* begin
    rd_byte = 8'h00;
    case (index)
      `IDX_INBAND_CODE_CONTROL: rd_byte = code_control_q;
      `IDX_TX_PATTERN_LOW: rd_byte = tx_low_q;
      `IDX_TX_PATTERN_HIGH: rd_byte = tx_high_q;
      `IDX_RX_LOOPUP_PATTERN_LOW: rd_byte = up_low_q;
      `IDX_RX_LOOPUP_PATTERN_HIGH: rd_byte = up_high_q;
      `IDX_RX_LOOPDOWN_PATTERN_LOW: rd_byte = down_low_q;
      `IDX_RX_LOOPDOWN_PATTERN_HIGH: rd_byte = down_high_q;
      `IDX_LOOPCODE_CONTROL: rd_byte[`TX_ENABLE_BIT] = tx_loopcode_enable_q;
      `IDX_LOOPCODE_STATUS: begin
        rd_byte[`STAT_UP_BIT] = up_live;
        rd_byte[`STAT_DOWN_BIT] = down_live;
      end
      `IDX_IRQ_STATUS: begin
        rd_byte[`IRQ_UP_BIT] = irq_status_q[1];
        rd_byte[`IRQ_DOWN_BIT] = irq_status_q[0];
      end
      `IDX_IRQ_MASK: begin
        rd_byte[`IRQ_UP_BIT] = irq_mask_q[1];
        rd_byte[`IRQ_DOWN_BIT] = irq_mask_q[0];
      end
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= request;
      if (request && !wb_we_i)
        dat_q <= {24'h000000, rd_byte};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // interrupt status
  // ****************************************
  // a rising detection in the same cycle as a clearing write still sets
  always @* begin
    irq_status_d = irq_status_q;
    if (wr_stb && index == `IDX_IRQ_STATUS) begin
      if (wb_dat_i[`IRQ_UP_BIT])
        irq_status_d[1] = 1'b0;
      if (wb_dat_i[`IRQ_DOWN_BIT])
        irq_status_d[0] = 1'b0;
    end
    if (up_live && !up_prev_q)
      irq_status_d[1] = 1'b1;
    if (down_live && !down_prev_q)
      irq_status_d[0] = 1'b1;
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      irq_status_q <= 2'b00;
      up_prev_q <= 1'b0;
      down_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      up_prev_q <= up_live;
      down_prev_q <= down_live;
      irq_q <= |(irq_status_d & irq_mask_q);
    end
  end

  assign irq_o = irq_q;

  // ****************************************
  // transmit pattern generator
  // ****************************************
  reg [15:0] tx_shift_q;
  reg [4:0] tx_count_q;
  reg tx_data_q;
  wire [15:0] tx_pattern;
  wire [4:0] tx_len;

  // low register leads, so its top bit starts every repetition
  assign tx_pattern = {tx_low_q, tx_high_q};
  assign tx_len = tx_length(code_control_q[`TX_LEN_MSB:`TX_LEN_LSB]);

  always @(posedge clock_i) begin
    if (rst_i) begin
      tx_shift_q <= 16'h0000;
      tx_count_q <= 5'h00;
      tx_data_q <= 1'b0;
    end else if (tx_bit_strobe_i) begin
      if (!tx_loopcode_enable_q) begin
        // disabled: line data passes and the next enable starts a fresh repetition
        tx_count_q <= 5'h00;
        tx_data_q <= tx_line_data_i;
      end else if (tx_count_q == 5'h00) begin
        // the pattern is sampled only here so rewrites never tear a repetition
        tx_data_q <= tx_pattern[15];
        tx_shift_q <= {tx_pattern[14:0], 1'b0};
        tx_count_q <= tx_len - 5'd1;
      end else begin
        tx_data_q <= tx_shift_q[15];
        tx_shift_q <= {tx_shift_q[14:0], 1'b0};
        tx_count_q <= tx_count_q - 5'd1;
      end
    end
  end

  assign tx_data_o = tx_data_q;

  // ****************************************
  // receive detectors
  // ****************************************
  wire [4:0] up_len;
  wire [4:0] down_len;
  assign up_len = rx_length(code_control_q[`UP_LEN_MSB:`UP_LEN_LSB]);
  assign down_len = rx_length(code_control_q[`DOWN_LEN_MSB:`DOWN_LEN_LSB]);

  // phase counts below the length, so bits past 8-N of the low byte stay unused
  loop_code_detector #(
    .PERIOD_CYCLES(INTEG_CYCLES)
  ) up_detector (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .bit_strobe_i(rx_bit_strobe_i),
    .bit_i(rx_data_i),
    .pattern_i({up_low_q, up_high_q}),
    .length_i(up_len),
    .detected_o(up_live)
  );

  loop_code_detector #(
    .PERIOD_CYCLES(INTEG_CYCLES)
  ) down_detector (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .bit_strobe_i(rx_bit_strobe_i),
    .bit_i(rx_data_i),
    .pattern_i({down_low_q, down_high_q}),
    .length_i(down_len),
    .detected_o(down_live)
  );

  assign loopup_detected_flag_o = up_live;
  assign loopdown_detected_flag_o = down_live;

endmodule // inband_loop_code_pattern_regs

// [loop_code_asserts.sv]
// port checker for the loop code block
// assumes it is bound to the block's top module
`timescale 1ns/100ps
module loop_code_asserts (
  input wire clock_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire tx_bit_strobe_i,
  input wire tx_data_o,
  input wire loopup_detected_flag_o,
  input wire loopdown_detected_flag_o,
  input wire irq_o
);
  // ****
  // properties
  // ****
  wire up = loopup_detected_flag_o;
  wire dn = loopdown_detected_flag_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (s_req |-> s_ans)
    else $error("ack missing or too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rd_upper: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_tx_hold: assert property (!tx_bit_strobe_i |=> $stable(tx_data_o))
    else $error("line bit moved without slot");
  a_up_hold: assert property ($changed(up) |=> $stable(up) [*8])
    else $error("loop-up flag not held");
  a_dn_hold: assert property ($changed(dn) |=> $stable(dn) [*8])
    else $error("loop-down flag not held");
  // irq may only rise with or just after a bus ack, or after a detection flag was high
  a_irq_cause: assert property ($rose(irq_o) |->
    wb_ack_o || $past(wb_ack_o) || $past(up) || $past(dn))
    else $error("irq without cause");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !irq_o && !tx_data_o && !up && !dn)
    else $error("outputs not quiet in reset");
endmodule // loop_code_asserts

bind inband_loop_code_pattern_regs loop_code_asserts chk (
  .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_bit_strobe_i(tx_bit_strobe_i),
  .tx_data_o(tx_data_o), .loopup_detected_flag_o(loopup_detected_flag_o),
  .loopdown_detected_flag_o(loopdown_detected_flag_o), .irq_o(irq_o));

// [remote_line_end.sv]
// far-end line model: sends a repeating code and clocks transmit slots
// assumes one bit slot every fourth system clock
`timescale 1ns/100ps
module remote_line_end (
  input wire clock_i,
  input wire rst_i,
  input wire send_i,
  input wire [15:0] code_i,
  input wire [4:0] len_i,
  input wire tx_run_i,
  output reg rx_strobe_o,
  output reg rx_bit_o,
  output reg tx_strobe_o
);
  // ****
  // line timing
  // ****
  reg [1:0] rdiv_q;
  reg [1:0] tdiv_q;
  reg [4:0] idx_q;
  always @(posedge clock_i) begin
    if (rst_i) begin
      rdiv_q <= 2'h0;
      tdiv_q <= 2'h0;
      idx_q <= 5'h00;
      rx_strobe_o <= 1'b0;
      rx_bit_o <= 1'b0;
      tx_strobe_o <= 1'b0;
    end else begin
      rdiv_q <= rdiv_q + 2'h1;
      rx_strobe_o <= send_i && rdiv_q == 2'h0;
      tdiv_q <= tx_run_i ? tdiv_q + 2'h1 : 2'h0;
      tx_strobe_o <= tx_run_i && tdiv_q == 2'h3;
      if (!send_i) begin
        // idle line carries no stale value
        rx_bit_o <= !rx_bit_o;
        idx_q <= 5'h00;
      end else if (rdiv_q == 2'h0) begin
        rx_bit_o <= code_i[5'h0F - idx_q];
        // a shorter code chosen mid-repetition wraps at once, never past the word
        idx_q <= (idx_q >= len_i - 5'h01) ? 5'h00 : idx_q + 5'h01;
      end
    end
  end
endmodule // remote_line_end

// [tb_top.sv]
// self-checking bench for the loop code block
// assumes the far-end model and the bound checker
`timescale 1ns/100ps
`define CHK(a, b) begin \
  cmp_count = cmp_count + 1; \
  if ((a) !== (b)) begin \
    num_errors = num_errors + 1; \
    $display("[ERR] %0t %h %h", $time, a, b); \
  end \
end
module tb_top;
  // ****
  // harness
  // ****
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg req = 1'b0;
  reg we = 1'b0;
  reg send = 1'b0;
  reg txrun = 1'b0;
  reg tx_line = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h00000000;
  reg [15:0] code = 16'h0000;
  reg [4:0] len = 5'h01;
  reg [7:0] a;
  reg [31:0] got;
  wire [31:0] rdat;
  wire ack, txs, txd, rxs, rxd, up, dn, irq;
  wire [2:0] outs = {up, dn, irq};
  integer num_errors = 0;
  integer cmp_count = 0;
  integer i, k, n;
  localparam [15:0] PAT = 16'hA73C;
  inband_loop_code_pattern_regs #(.INTEG_CYCLES(2000)) uut (
    .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_bit_strobe_i(txs), .tx_line_data_i(tx_line), .tx_data_o(txd),
    .rx_bit_strobe_i(rxs), .rx_data_i(rxd), .loopup_detected_flag_o(up),
    .loopdown_detected_flag_o(dn), .irq_o(irq));
  remote_line_end far (
    .clock_i(clock_i), .rst_i(rst_i), .send_i(send), .code_i(code), .len_i(len),
    .tx_run_i(txrun), .rx_strobe_o(rxs), .rx_bit_o(rxd), .tx_strobe_o(txs));
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  task bus(input w, input [7:0] ad, input [7:0] d);
    begin
      @(posedge clock_i);
      req <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= {24'h000000, d};
      do @(posedge clock_i); while (ack !== 1'b1);
      got = rdat;
      req <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] e);
    begin
      bus(1'b0, ad, 8'h00);
      `CHK(got, {24'h000000, e})
    end
  endtask
  task slot;
    begin
      do @(posedge clock_i); while (txs !== 1'b1);
      @(posedge clock_i);
    end
  endtask
  task wait_flag(input integer which);
    begin
      for (n = 0; n < 8000 && outs[which] !== 1'b1; n = n + 1) @(posedge clock_i);
      repeat (4) @(posedge clock_i);
    end
  endtask
  task rst_dut;
    begin
      rst_i <= 1'b1;
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
    end
  endtask
  task summarize;
    begin
      if (num_errors == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // ****
  // tests
  // ****
  initial begin
    rst_dut;
    for (a = 8'h2C; a < 8'h44; a = a + 8'h04) rd(a, 8'h00);
    for (a = 8'h2C; a < 8'h44; a = a + 8'h04) bus(1'b1, a, a ^ 8'h5A);
    for (a = 8'h2C; a < 8'h44; a = a + 8'h04) rd(a, a ^ 8'h5A);
    rd(8'h7C, 8'h00);
    // each length starts from reset so the first slot is repetition bit 0
    for (i = 0; i < 4; i = i + 1) begin
      // slots stop while the generator is set up, so the first slot is always bit 0
      txrun <= 1'b0;
      rst_dut;
      bus(1'b1, 8'h28, {i[1:0], 6'h00});
      bus(1'b1, 8'h2C, PAT[15:8]);
      bus(1'b1, 8'h30, PAT[7:0]);
      bus(1'b1, 8'h4C, 8'h08);
      rd(8'h4C, 8'h08);
      txrun <= 1'b1;
      k = (i == 3) ? 16 : i + 5;
      for (n = 0; n < 2 * k; n = n + 1) begin
        slot;
        `CHK(txd, PAT[15 - n % k])
      end
    end
    bus(1'b1, 8'h4C, 8'h00);
    for (n = 0; n < 2; n = n + 1) begin
      tx_line <= n[0];
      slot;
      `CHK(txd, n[0])
    end
    txrun <= 1'b0;
    bus(1'b1, 8'h28, 8'h22);
    bus(1'b1, 8'h34, 8'h87);
    bus(1'b1, 8'h3C, 8'hDF);
    bus(1'b1, 8'h58, 8'h03);
    code <= 16'h8000;
    len <= 5'd5;
    send <= 1'b1;
    wait_flag(2);
    `CHK(outs, 3'b101)
    rd(8'h54, 8'h02);
    bus(1'b1, 8'h54, 8'h02);
    repeat (2) @(posedge clock_i);
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h58, 8'h00);
    code <= 16'hC000;
    len <= 5'd3;
    wait_flag(1);
    `CHK(outs, 3'b010)
    rd(8'h54, 8'h01);
    bus(1'b1, 8'h58, 8'h01);
    repeat (2) @(posedge clock_i);
    `CHK(irq, 1'b1)
    bus(1'b1, 8'h54, 8'h01);
    repeat (2) @(posedge clock_i);
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h28, 8'h3A);
    bus(1'b1, 8'h34, PAT[15:8]);
    bus(1'b1, 8'h38, PAT[7:0]);
    code <= PAT;
    len <= 5'd16;
    wait_flag(2);
    `CHK(outs, 3'b100)
    rd(8'h28, 8'h3A);
    rd(8'h50, 8'h80);
    rd(8'h54, 8'h02);
    rd(8'h58, 8'h01);
    summarize;
  end
  // run needs about 10k cycles; give up after 50k
  initial begin
    #1000000;
    num_errors = num_errors + 1;
    summarize;
  end
endmodule // tb_top
